// ### hdl/group_sel_pkg.sv
// package: constants, register map and carrier types of the setting group selector
package group_sel_pkg;

    localparam int NUM_GROUPS = 8;
    localparam int NUM_EVENTS = 30;
    localparam int STAMP_W    = 32;
    localparam int GSEL_W     = 4;    // group field: 0 none, 1..8 group number
    localparam int IDX_W      = 3;    // active group index, 0 is group one

    // register byte offsets (word aligned)
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_FORCE     = 8'h04;
    localparam logic [7:0] OFS_REMOTE    = 8'h08;
    localparam logic [7:0] OFS_LOCAL     = 8'h0c;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam logic [7:0] OFS_ON_MASK   = 8'h14;
    localparam logic [7:0] OFS_OFF_MASK  = 8'h18;
    localparam logic [7:0] OFS_STAMP     = 8'h1c;
    localparam logic [7:0] OFS_EVT_STATE = 8'h20;

    // control register fields
    localparam int CTRL_FORCE_BIT = 0;
    localparam int CTRL_USED_LSB  = 4;   // used groups minus one, 3 bits

    // status register fields
    localparam int STAT_ACTIVE_LSB = 0;
    localparam int STAT_FORCE_BIT  = 3;
    localparam int STAT_FAIL_LSB   = 4;  // not configured, force, lower priority
    localparam int STAT_REQ_LSB    = 8;
    localparam int STAT_HELD_LSB   = 16;

    // event codes, one bit each in the event vectors
    localparam int EVT_ENABLED_BASE = 0;
    localparam int EVT_REQUEST_BASE = 8;
    localparam int EVT_ACTIVE_BASE  = 16;
    localparam int EVT_REMOTE       = 24;
    localparam int EVT_LOCAL        = 25;
    localparam int EVT_FORCE        = 26;
    localparam int EVT_FAIL_NOTCFG  = 27;
    localparam int EVT_FAIL_FORCE   = 28;
    localparam int EVT_FAIL_LOWER   = 29;

    // reset values
    localparam logic [IDX_W-1:0]      ACTIVE_RST   = 3'h0;
    localparam logic [IDX_W-1:0]      USED_M1_RST  = 3'h0;
    localparam logic [NUM_EVENTS-1:0] MASK_RST     = 30'h3fffffff;
    // group one enabled and active after reset, so no spurious edge then
    localparam logic [NUM_EVENTS-1:0] COND_RST     = 30'h00010001;
    // a held level of group eight blocks nobody
    localparam logic [NUM_GROUPS-1:0] BLOCKING_MASK = 8'h7f;

    // timestamped event report
    typedef struct packed {
        logic [NUM_EVENTS-1:0] on_vec;
        logic [NUM_EVENTS-1:0] off_vec;
        logic [STAMP_W-1:0]    stamp;
    } event_t;

    // ahb-lite slave answer
    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } ahb_resp_t;

endpackage

// ### hdl/group_selector_block.sv
// setting group selector: fixed priority group selection, events, ahb-lite registers
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module group_selector_block #(
    parameter int HOLD_CYCLES = 2   // consecutive high cycles after which a request is static
) (
    input  wire logic                                        ref_clk,
    input  wire logic                                        rst,
    input  wire logic [group_sel_pkg::NUM_GROUPS-1:0]        group_request,
    input  wire logic                                        hsel,
    input  wire logic [31:0]                                 haddr,
    input  wire logic [1:0]                                  htrans,
    input  wire logic                                        hwrite,
    input  wire logic [2:0]                                  hsize,
    input  wire logic [31:0]                                 hwdata,
    input  wire logic                                        hready,
    output group_sel_pkg::ahb_resp_t                         ahb_resp,
    output logic [group_sel_pkg::IDX_W-1:0]                  active_group,
    output logic                                             forced_group_enable,
    output group_sel_pkg::event_t                            event_out
);

    localparam int CNT_W = 4;

    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 15) begin : g_bad_hold
        $error("HOLD_CYCLES must lie between 1 and 15");
    end

    localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_CYCLES);

    typedef struct packed {
        logic [group_sel_pkg::NUM_GROUPS-1:0]            req_prev;
        logic [group_sel_pkg::NUM_GROUPS-1:0]            held_prev;
        logic [group_sel_pkg::NUM_GROUPS-1:0][CNT_W-1:0] hold_cnt;
        logic [group_sel_pkg::IDX_W-1:0]                 active;
        logic                                            force_en;
        logic [group_sel_pkg::IDX_W-1:0]                 used_m1;
        logic [group_sel_pkg::GSEL_W-1:0]                force_sel;
        logic [group_sel_pkg::GSEL_W-1:0]                remote_sel;
        logic [group_sel_pkg::GSEL_W-1:0]                local_sel;
        logic                                            fail_notcfg;
        logic                                            fail_force;
        logic                                            fail_lower;
        logic [group_sel_pkg::NUM_EVENTS-1:0]            on_mask;
        logic [group_sel_pkg::NUM_EVENTS-1:0]            off_mask;
        logic [group_sel_pkg::NUM_EVENTS-1:0]            cond_prev;
        logic [group_sel_pkg::STAMP_W-1:0]               clock_stamp;
        group_sel_pkg::event_t                           evt;
        logic                                            wr_pend;
        logic [7:0]                                      wr_addr;
        group_sel_pkg::ahb_resp_t                        resp;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // true when a group ranked above idx is held by a static level
    function automatic logic higher_held(input logic [7:0] held, input logic [2:0] idx);
        logic [7:0] above;
        above = 8'h00;
        for (int k = 0; k < group_sel_pkg::NUM_GROUPS; k++) begin
            if (k < int'(idx)) begin
                above[k] = 1'b1;
            end
        end
        return |(held & group_sel_pkg::BLOCKING_MASK & above);
    endfunction

    // lowest set index, i.e. highest rank; found flag in the top bit
    function automatic logic [3:0] pick_first(input logic [7:0] vec);
        logic [3:0] res;
        res = 4'h0;
        for (int k = group_sel_pkg::NUM_GROUPS - 1; k >= 0; k--) begin
            if (vec[k]) begin
                res = {1'b1, 3'(k)};
            end
        end
        return res;
    endfunction

    // working signals of the selection
    logic [7:0]  rise;
    logic [7:0]  held;
    logic [7:0]  enabled;
    logic [7:0]  auto_cand;
    logic [7:0]  auto_ok;
    logic [3:0]  auto_pick;
    logic        reopen;
    logic        sw_req;
    logic        sw_is_force;
    logic [3:0]  sw_group;
    logic [2:0]  sw_idx;
    logic [3:0]  used_cnt;
    logic        set_notcfg;
    logic        set_force;
    logic        set_lower;
    logic        accept;
    logic [2:0]  accept_idx;
    logic [29:0] cond;
    logic [29:0] ev_on;
    logic [29:0] ev_off;
    logic [31:0] rd_word;

    // request classification: pulses are rising edges, a level held long enough is static
    always_comb begin
        used_cnt = {1'b0, state_reg.used_m1} + 4'h1;
        for (int i = 0; i < group_sel_pkg::NUM_GROUPS; i++) begin
            rise[i]    = group_request[i] & ~state_reg.req_prev[i];
            held[i]    = group_request[i] & (state_reg.hold_cnt[i] == HOLD_CNT);
            enabled[i] = 3'(i) <= state_reg.used_m1;
        end
        // held groups compete again when the active static group lets go or forcing ends
        reopen = (state_reg.held_prev[state_reg.active] & ~held[state_reg.active])
               | (state_reg.cond_prev[group_sel_pkg::EVT_FORCE] & ~state_reg.force_en);
        auto_cand = rise | (held & ~state_reg.held_prev) | (reopen ? held : 8'h00);
        for (int i = 0; i < group_sel_pkg::NUM_GROUPS; i++) begin
            auto_ok[i] = auto_cand[i] & enabled[i] & ~higher_held(held, 3'(i));
        end
        auto_pick = pick_first(auto_ok);
    end

    // software requests: force, remote and local selections written over the bus
    always_comb begin
        sw_req      = 1'b0;
        sw_is_force = 1'b0;
        sw_group    = 4'h0;
        if (state_reg.wr_pend) begin
            unique case (state_reg.wr_addr)
                group_sel_pkg::OFS_FORCE: begin
                    sw_req      = |hwdata[3:0];
                    sw_is_force = 1'b1;
                    sw_group    = hwdata[3:0];
                end
                group_sel_pkg::OFS_REMOTE, group_sel_pkg::OFS_LOCAL: begin
                    sw_req   = |hwdata[3:0];
                    sw_group = hwdata[3:0];
                end
                default: begin
                    sw_req = 1'b0;
                end
            endcase
        end
        sw_idx = 3'(sw_group - 4'h1);
    end

    // acceptance and failure decisions
    always_comb begin
        set_notcfg = 1'b0;
        set_force  = 1'b0;
        set_lower  = 1'b0;
        accept     = 1'b0;
        accept_idx = state_reg.active;
        if (state_reg.force_en) begin
            // input pulses are ignored; only the written selections act, a held higher group still blocks remote and local
            if (sw_req) begin
                if (sw_group > used_cnt) begin
                    set_notcfg = 1'b1;
                end else if (!sw_is_force && higher_held(held, sw_idx)) begin
                    set_lower = 1'b1;
                end else begin
                    accept     = 1'b1;
                    accept_idx = sw_idx;
                end
            end
        end else begin
            if (sw_req) begin
                if (sw_group > used_cnt) begin
                    set_notcfg = 1'b1;
                end else begin
                    set_force = 1'b1;
                end
            end
            set_notcfg = set_notcfg | |(rise & ~enabled);
            set_lower  = |(auto_cand & enabled & ~auto_ok);
            if (auto_pick[3]) begin
                accept     = 1'b1;
                accept_idx = auto_pick[2:0];
            end
        end
    end

    // tracked conditions and their edges
    always_comb begin
        cond = '0;
        for (int i = 0; i < group_sel_pkg::NUM_GROUPS; i++) begin
            cond[group_sel_pkg::EVT_ENABLED_BASE + i] = enabled[i];
            cond[group_sel_pkg::EVT_REQUEST_BASE + i] = group_request[i];
            cond[group_sel_pkg::EVT_ACTIVE_BASE + i]  = state_reg.active == 3'(i);
        end
        cond[group_sel_pkg::EVT_REMOTE]      = |state_reg.remote_sel;
        cond[group_sel_pkg::EVT_LOCAL]       = |state_reg.local_sel;
        cond[group_sel_pkg::EVT_FORCE]       = state_reg.force_en;
        cond[group_sel_pkg::EVT_FAIL_NOTCFG] = state_reg.fail_notcfg;
        cond[group_sel_pkg::EVT_FAIL_FORCE]  = state_reg.fail_force;
        cond[group_sel_pkg::EVT_FAIL_LOWER]  = state_reg.fail_lower;
        ev_on  = cond & ~state_reg.cond_prev & state_reg.on_mask;
        ev_off = ~cond & state_reg.cond_prev & state_reg.off_mask;
    end

    // register read mux, sampled in the address phase
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (haddr[7:0])
            group_sel_pkg::OFS_CONTROL: begin
                rd_word[group_sel_pkg::CTRL_FORCE_BIT] = state_reg.force_en;
                rd_word[group_sel_pkg::CTRL_USED_LSB +: 3] = state_reg.used_m1;
            end
            group_sel_pkg::OFS_FORCE:    rd_word[3:0] = state_reg.force_sel;
            group_sel_pkg::OFS_REMOTE:   rd_word[3:0] = state_reg.remote_sel;
            group_sel_pkg::OFS_LOCAL:    rd_word[3:0] = state_reg.local_sel;
            group_sel_pkg::OFS_STATUS: begin
                rd_word[group_sel_pkg::STAT_ACTIVE_LSB +: 3] = state_reg.active;
                rd_word[group_sel_pkg::STAT_FORCE_BIT] = state_reg.force_en;
                rd_word[group_sel_pkg::STAT_FAIL_LSB +: 3] =
                    {state_reg.fail_lower, state_reg.fail_force, state_reg.fail_notcfg};
                rd_word[group_sel_pkg::STAT_REQ_LSB +: 8]  = group_request;
                rd_word[group_sel_pkg::STAT_HELD_LSB +: 8] = held;
            end
            group_sel_pkg::OFS_ON_MASK:   rd_word[29:0] = state_reg.on_mask;
            group_sel_pkg::OFS_OFF_MASK:  rd_word[29:0] = state_reg.off_mask;
            group_sel_pkg::OFS_STAMP:     rd_word = state_reg.clock_stamp;
            group_sel_pkg::OFS_EVT_STATE: rd_word[29:0] = cond;
            default:                      rd_word = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    // next state
    always_comb begin
        state_next             = state_reg;
        state_next.clock_stamp = state_reg.clock_stamp + 32'h0000_0001;
        state_next.req_prev    = group_request;
        state_next.held_prev   = held;
        for (int i = 0; i < group_sel_pkg::NUM_GROUPS; i++) begin
            if (!group_request[i]) begin
                state_next.hold_cnt[i] = '0;
            end else if (state_reg.hold_cnt[i] != HOLD_CNT) begin
                state_next.hold_cnt[i] = state_reg.hold_cnt[i] + 4'h1;
            end
        end

        // active group only moves on an accepted request
        if (accept) begin
            state_next.active = accept_idx;
        end

        // failures clear on a success, but a fresh failure wins
        if (accept) begin
            state_next.fail_notcfg = 1'b0;
            state_next.fail_force  = 1'b0;
            state_next.fail_lower  = 1'b0;
        end
        if (set_notcfg) begin
            state_next.fail_notcfg = 1'b1;
        end
        if (set_force) begin
            state_next.fail_force = 1'b1;
        end
        if (set_lower) begin
            state_next.fail_lower = 1'b1;
        end

        // data phase of a write
        if (state_reg.wr_pend) begin
            unique case (state_reg.wr_addr)
                group_sel_pkg::OFS_CONTROL: begin
                    state_next.force_en = hwdata[group_sel_pkg::CTRL_FORCE_BIT];
                    state_next.used_m1  = hwdata[group_sel_pkg::CTRL_USED_LSB +: 3];
                end
                group_sel_pkg::OFS_FORCE:    state_next.force_sel  = hwdata[3:0];
                group_sel_pkg::OFS_REMOTE:   state_next.remote_sel = hwdata[3:0];
                group_sel_pkg::OFS_LOCAL:    state_next.local_sel  = hwdata[3:0];
                group_sel_pkg::OFS_ON_MASK:  state_next.on_mask    = hwdata[29:0];
                group_sel_pkg::OFS_OFF_MASK: state_next.off_mask   = hwdata[29:0];
                default: begin
                    state_next.wr_pend = 1'b0; // read-only or unmapped: ignored
                end
            endcase
        end

        // event report one cycle after the tracked change
        state_next.cond_prev   = cond;
        state_next.evt.on_vec  = ev_on;
        state_next.evt.off_vec = ev_off;
        if (|(ev_on | ev_off)) begin
            state_next.evt.stamp = state_reg.clock_stamp;
        end

        // ahb-lite address phase; zero wait states, always okay
        state_next.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            state_next.wr_pend = hwrite;
            state_next.wr_addr = haddr[7:0];
            if (!hwrite) begin
                state_next.resp.hrdata = rd_word;
            end
        end
        state_next.resp.hreadyout = 1'b1;
        state_next.resp.hresp     = 1'b0;
    end

    // one register bank holds the whole state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg             <= '0;
            state_reg.active      <= group_sel_pkg::ACTIVE_RST;
            state_reg.used_m1     <= group_sel_pkg::USED_M1_RST;
            state_reg.on_mask     <= group_sel_pkg::MASK_RST;
            state_reg.off_mask    <= group_sel_pkg::MASK_RST;
            state_reg.cond_prev   <= group_sel_pkg::COND_RST;
            state_reg.resp.hreadyout <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ahb_resp            = state_reg.resp;
    assign active_group        = state_reg.active;
    assign forced_group_enable = state_reg.force_en;
    assign event_out           = state_reg.evt;

endmodule // group_selector_block

// ### tb/group_req_src.sv
// partner model: internal logic that drives the group requests as pulses or held levels
`timescale 1ns/1ns
module group_req_src (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [7:0] pulse_cmd,
    input  wire logic [7:0] level_cmd,
    output logic      [7:0] group_request
);
    // a pulse command lasts one cycle, a level lasts while set; silent during reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            group_request <= 8'h00;
        end else begin
            group_request <= pulse_cmd | level_cmd;
        end
    end
endmodule // group_req_src

// ### tb/group_sel_chk.sv
// checker: port level properties of the setting group selector
`timescale 1ns/1ns
module group_sel_chk #(
    parameter int HOLD_CYCLES = 2
) (
    input wire logic                     ref_clk,
    input wire logic                     rst,
    input wire logic [7:0]               group_request,
    input wire logic                     hsel,
    input wire logic [31:0]              haddr,
    input wire logic [1:0]               htrans,
    input wire logic                     hwrite,
    input wire logic [2:0]               hsize,
    input wire logic [31:0]              hwdata,
    input wire logic                     hready,
    input wire group_sel_pkg::ahb_resp_t ahb_resp,
    input wire logic [2:0]               active_group,
    input wire logic                     forced_group_enable,
    input wire group_sel_pkg::event_t    event_out
);
    logic wr_dph;
    // write data phase marker: a software request may move the group at that edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_dph <= 1'b0;
        end else begin
            wr_dph <= hsel & htrans[1] & hready & hwrite;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_group_one_rise: assert property ($rose(group_request[0]) && !forced_group_enable
        && !wr_dph |=> active_group == 3'h0) else $error("group one pulse not taken");
    a_group_one_held: assert property ((group_request[0] && !forced_group_enable
        && !wr_dph) [*3] |=> active_group == 3'h0) else $error("held group one lost");
    a_no_fallback: assert property (!$stable(active_group) |->
        $past(group_request) != 8'h00 || $past(wr_dph)) else $error("group moved uncaused");
    a_active_event: assert property (|event_out.on_vec[23:16] |->
        $past(active_group) != $past(active_group, 2)) else $error("stray active event");
    a_force_event: assert property (event_out.on_vec[group_sel_pkg::EVT_FORCE] |->
        $past(forced_group_enable) && !$past(forced_group_enable, 2))
        else $error("stray force event");
    a_request_event: assert property (event_out.on_vec[15:8] ==
        ($past(group_request) & ~$past(group_request, 2)) && event_out.off_vec[15:8] ==
        (~$past(group_request) & $past(group_request, 2))) else $error("request event");
    a_stamp_hold: assert property (event_out.on_vec == '0 && event_out.off_vec == '0
        |-> $stable(event_out.stamp)) else $error("stamp moved without event");
    a_pulse_once: assert property ((event_out.on_vec & $past(event_out.on_vec)) == '0)
        else $error("event pulse longer than one cycle");
    c_group_eight: cover property (active_group == 3'h7);
    c_force_on: cover property ($rose(forced_group_enable));
    c_fail_lower: cover property (event_out.on_vec[group_sel_pkg::EVT_FAIL_LOWER]);
endmodule // group_sel_chk

bind group_selector_block group_sel_chk #(.HOLD_CYCLES(HOLD_CYCLES)) group_sel_chk_inst (
    .ref_clk(ref_clk), .rst(rst), .group_request(group_request), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .ahb_resp(ahb_resp), .active_group(active_group),
    .forced_group_enable(forced_group_enable), .event_out(event_out));

// ### tb/tb.sv
// testbench: priority selection, blocking, software requests and event reports
`timescale 1ns/1ns
module tb;
    logic                     ref_clk, rst, hsel, hwrite, hready, fen;
    logic                     clr_tgl, clr_seen;
    logic [31:0]              haddr, hwdata, rd, last_stamp;
    logic [1:0]               htrans;
    logic [2:0]               hsize, act;
    logic [7:0]               pulse_cmd, level_cmd, group_request;
    logic [29:0]              on_acc, off_acc;
    group_sel_pkg::ahb_resp_t ahb_resp;
    group_sel_pkg::event_t    event_out;
    int                       failures, compares, seed, g;

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    assign hready = ahb_resp.hreadyout; // single slave drives the bus ready

    group_req_src group_req_src_inst (.ref_clk(ref_clk), .rst(rst), .pulse_cmd(pulse_cmd),
        .level_cmd(level_cmd), .group_request(group_request));
    group_selector_block #(.HOLD_CYCLES(1)) group_selector_block_inst (.ref_clk(ref_clk),
        .rst(rst), .group_request(group_request), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .ahb_resp(ahb_resp), .active_group(act), .forced_group_enable(fen),
        .event_out(event_out));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one single ahb-lite transfer; read data is taken at the closing edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = ahb_resp.hrdata;
        chk("okay response", 0, ahb_resp.hresp);
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic pulse(input logic [7:0] m);
        pulse_cmd <= m;
        @(posedge ref_clk);
        pulse_cmd <= 8'h00;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic lvl(input logic [7:0] m);
        level_cmd <= m;
        repeat (4) @(posedge ref_clk);
    endtask

    // sticky record of reported edges; a toggle asks the recorder to restart at the next edge
    task automatic clr();
        clr_tgl <= ~clr_tgl;
    endtask

    // recorder has the accumulators to itself, so the bench never races it for them
    always @(posedge ref_clk) begin
        if (rst) begin
            on_acc <= '0;
            off_acc <= '0;
            last_stamp <= '0;
            clr_seen <= clr_tgl;
        end else begin
            if (clr_tgl != clr_seen) begin
                on_acc <= event_out.on_vec;
                off_acc <= event_out.off_vec;
            end else begin
                on_acc <= on_acc | event_out.on_vec;
                off_acc <= off_acc | event_out.off_vec;
            end
            clr_seen <= clr_tgl;
            // every report must carry a later stamp than the one before
            if (|{event_out.on_vec, event_out.off_vec}) begin
                chk("stamp order", 1, event_out.stamp > last_stamp);
                last_stamp <= event_out.stamp;
            end
        end
    end

    initial begin
        repeat (3000) @(posedge ref_clk);
        failures++;
        complete_run();
    end

    initial begin
        seed = 57733;
        {rst, hsel, hwrite, htrans, haddr, hwdata, hsize} = {3'b100, 66'h0, 3'h2};
        {pulse_cmd, level_cmd, clr_tgl} = '0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("active after reset", 0, act);
        bus(0, 8'h14, 0);
        chk("on mask reset", 32'h3fffffff, rd);
        bus(0, 8'h40, 0);
        chk("unmapped read", 0, rd);
        pulse(8'h04);
        chk("unused group", 0, act);
        bus(0, 8'h10, 0);
        chk("not configured flag", 1, rd[4]);
        clr();
        bus(1, 8'h00, 32'h70);
        @(posedge ref_clk); // the recorder takes the last pulse at the edge the task ended on
        chk("group eight enabled event", 1, on_acc[7]);
        // the model: the lowest set index wins and stays until another request
        for (int i = 0; i < 6; i++) begin
            g = $unsigned($random(seed)) % 8;
            pulse(8'h01 << g);
            chk("pulsed group", g, act);
        end
        pulse(8'h60);
        chk("two pulses", 5, act);
        repeat (5) @(posedge ref_clk);
        chk("kept group", 5, act);
        lvl(8'h04);
        chk("held three", 2, act);
        pulse(8'h20);
        chk("blocked lower", 2, act);
        bus(0, 8'h10, 0);
        chk("lower fail flag", 1, rd[6]);
        pulse(8'h02);
        chk("higher passes", 1, act);
        lvl(8'h80);
        chk("held eight", 7, act);
        pulse(8'h10);
        chk("eight blocks none", 4, act);
        lvl(8'h01);
        chk("held one", 0, act);
        pulse(8'h02);
        chk("one blocks pulse", 0, act);
        clr();
        bus(1, 8'h08, 32'h4);
        bus(0, 8'h10, 0);
        chk("force fail flag", 1, rd[5]);
        bus(1, 8'h00, 32'h71);
        chk("force on", 1, fen);
        bus(1, 8'h08, 32'h3);
        chk("one blocks remote", 0, act);
        lvl(8'h00);
        pulse(8'h08);
        chk("input ignored forced", 0, act);
        bus(1, 8'h0c, 32'h3);
        chk("local change", 2, act);
        bus(1, 8'h08, 32'h8);
        chk("remote change", 7, act);
        bus(1, 8'h04, 32'h6);
        chk("forced change", 5, act);
        bus(1, 8'h08, 32'h0);
        bus(1, 8'h0c, 32'h0);
        bus(1, 8'h00, 32'h70);
        chk("no fallback", 5, act);
        @(posedge ref_clk);
        chk("remote events", 2'b11, {on_acc[24], off_acc[24]});
        chk("local events", 2'b11, {on_acc[25], off_acc[25]});
        chk("force events", 2'b11, {on_acc[26], off_acc[26]});
        bus(1, 8'h14, 32'h3ffbffff);
        clr();
        pulse(8'h04);
        @(posedge ref_clk);
        chk("masked active on", 3'b011, {on_acc[18], off_acc[21], on_acc[10]});
        complete_run();
    end
endmodule // tb
